// >>> hw/mmio_defines.svh
// What this block does
// - Port A alt-select routes sync or PWM outputs.
// - Cleared alt bit drives port A level bit.
// - Level zero drives low, one weak high.
// - Data register reads return live pin levels.
// - Port B: enable drives level, else pull-up.
// - Pin B6 is interrupt input when enabled and B6 output enable is clear.
// - Second I2C enable takes pins B5, B4.
// - Test-pattern enable drives pattern onto B3.
// - Divider enable: B1 input, B0 output.
// - Port C behaves like port B.
// - A/D-assigned C0, C1 lose their pull-up.
// - Port D resets to open-drain DDC lines.
// - GPIO port D: enables bits 3..2, levels 1..0.
`ifndef MMIO_DEFINES_SVH
`define MMIO_DEFINES_SVH

`define MMIO_IDX_W          6
`define MMIO_IDX_LSB        2
`define MMIO_IDX_MSB        7
`define MMIO_IDX_PD         6'h0F
`define MMIO_IDX_PA_ALT     6'h10
`define MMIO_IDX_PA_LVL     6'h11
`define MMIO_IDX_PB_OE      6'h12
`define MMIO_IDX_PB_LVL     6'h13
`define MMIO_IDX_PC_OE      6'h14
`define MMIO_IDX_PC_LVL     6'h15
`define MMIO_IDX_CTRL       6'h18
`define MMIO_IDX_MODE       6'h19

`define MMIO_RST_PD         5'h00
`define MMIO_RST_PA_ALT     8'h00
`define MMIO_RST_PA_LVL     8'hFF
`define MMIO_RST_PB_OE      7'h00
`define MMIO_RST_PB_LVL     7'h7F
`define MMIO_RST_PC_OE      8'h00
`define MMIO_RST_PC_LVL     8'hFF
`define MMIO_RST_CTRL       6'h00
`define MMIO_RST_PAD        8'hFF

`define MMIO_PD_GPIO        4
`define MMIO_PD_OE_MSB      3
`define MMIO_PD_OE_LSB      2
`define MMIO_PD_LVL_MSB     1

`define MMIO_CTL_IRQ        0
`define MMIO_CTL_IIC2       1
`define MMIO_CTL_PAT        2
`define MMIO_CTL_DIV        3
`define MMIO_CTL_ADC0       4
`define MMIO_CTL_ADC1       5

`define MMIO_PB_FIXED       7
`define MMIO_PB_IRQ         6
`define MMIO_PB_SDA         5
`define MMIO_PB_SCL         4
`define MMIO_PB_PAT         3
`define MMIO_PB_DIVI        1
`define MMIO_PB_DIVO        0

`define MMIO_HTRANS_ACT     1
`define MMIO_HSIZE_WORD     3'h2
`define MMIO_HRESP_OKAY     1'h0

`endif

// >>> hw/mmio_pkg.sv
`default_nettype none
`include "mmio_defines.svh"
package mmio_pkg;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] pull;
    } mmio_pad_t;
    typedef struct packed {
        logic                   en;
        logic [`MMIO_IDX_W-1:0] idx;
        logic [7:0]             data;
    } mmio_wr_t;
endpackage
`default_nettype wire

// >>> hw/mmio_pad_bank.sv
`default_nettype none
`include "mmio_defines.svh"
module mmio_pad_bank #(
    parameter logic [7:0] RST_PULL = `MMIO_RST_PAD
) (
    // Clock and reset.
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Pad drive in and out.
    input  wire mmio_pkg::mmio_pad_t next_pad_i,
    output var  mmio_pkg::mmio_pad_t pad_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pad_o.out  <= `MMIO_RST_PAD;
            pad_o.oe_n <= `MMIO_RST_PAD;
            pad_o.pull <= RST_PULL;
        end else begin
            pad_o <= next_pad_i;
        end
    end
endmodule
`default_nettype wire

// >>> hw/mmio_ahb_slave.sv
`default_nettype none
`include "mmio_defines.svh"
module mmio_ahb_slave (
    // Clock and reset.
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // AHB-Lite slave.
    input  wire logic                   hsel_i,
    input  wire logic [31:0]            haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic [2:0]             hsize_i,
    input  wire logic                   hready_i,
    input  wire logic [31:0]            hwdata_i,
    output logic                        hreadyout_o,
    output logic                        hresp_o,
    output logic [31:0]                 hrdata_o,
    // Register file side.
    output wire logic [`MMIO_IDX_W-1:0] rd_idx_o,
    input  wire logic [7:0]             rd_data_i,
    output var  mmio_pkg::mmio_wr_t     wr_o
);
    logic                   wr_pend;
    logic [`MMIO_IDX_W-1:0] wr_idx;
    wire take = hsel_i & hready_i & htrans_i[`MMIO_HTRANS_ACT];
    wire is_rd = take & ~hwrite_i;
    // Only whole-word writes reach the registers.
    wire is_wr = take & hwrite_i & (hsize_i == `MMIO_HSIZE_WORD);

    assign rd_idx_o   = haddr_i[`MMIO_IDX_MSB:`MMIO_IDX_LSB];
    assign wr_o.en    = wr_pend;
    assign wr_o.idx   = wr_idx;
    assign wr_o.data  = hwdata_i[7:0];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend     <= 1'b0;
            wr_idx      <= '0;
            hrdata_o    <= '0;
            hreadyout_o <= 1'b1;
            hresp_o     <= `MMIO_HRESP_OKAY;
        end else begin
            wr_pend     <= is_wr;
            hreadyout_o <= 1'b1;
            hresp_o     <= `MMIO_HRESP_OKAY;
            if (is_wr) begin
                wr_idx <= rd_idx_o;
            end
            if (is_rd) begin
                hrdata_o <= {24'h000000, rd_data_i};
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/mmio_io_ports.sv
// The AHB-Lite interface to the registers was decided locally.
`default_nettype none
`include "mmio_defines.svh"
module mmio_io_ports (
    // Clock and reset.
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // AHB-Lite slave.
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic                hready_i,
    input  wire logic [31:0]         hwdata_i,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    output logic [31:0]              hrdata_o,
    // Live pin levels.
    input  wire logic [7:0]          porta_pin_i,
    input  wire logic [7:0]          portb_pin_i,
    input  wire logic [7:0]          portc_pin_i,
    input  wire logic [1:0]          portd_pin_i,
    // Pad drives.
    output var  mmio_pkg::mmio_pad_t porta_pad_o,
    output var  mmio_pkg::mmio_pad_t portb_pad_o,
    output var  mmio_pkg::mmio_pad_t portc_pad_o,
    output var  mmio_pkg::mmio_pad_t portd_pad_o,
    // Alternate function sources.
    input  wire logic                hsync_out_pin_i,
    input  wire logic                vsync_out_pin_i,
    input  wire logic [5:0]          pwm_channel_i,
    input  wire logic                pattern_out_pin_i,
    input  wire logic                divider_out_pin_i,
    input  wire logic                iic2_clock_pin_i,
    input  wire logic                iic2_data_pin_i,
    input  wire logic                ddc_clock_pin_i,
    input  wire logic                ddc_data_pin_i,
    // Alternate function sinks.
    output logic                     ext_irq_pin_o,
    output logic                     iic2_clock_pin_o,
    output logic                     iic2_data_pin_o,
    output logic                     divider_in_pin_o,
    output logic                     ddc_clock_pin_o,
    output logic                     ddc_data_pin_o
);
    mmio_pkg::mmio_wr_t     wr;
    logic [`MMIO_IDX_W-1:0] rd_idx;
    logic [7:0]             rd_data;

    logic [4:0] port_d_control;
    logic [7:0] port_a_alt_select;
    logic [7:0] port_a_level;
    logic [6:0] port_b_output_enable;
    logic [6:0] port_b_level;
    logic [7:0] port_c_output_enable;
    logic [7:0] port_c_level;
    logic [5:0] pin_function_control;

    mmio_pkg::mmio_pad_t next_pa;
    mmio_pkg::mmio_pad_t next_pb;
    mmio_pkg::mmio_pad_t next_pc;
    mmio_pkg::mmio_pad_t next_pd;
    mmio_pkg::mmio_pad_t pb_gpio;
    mmio_pkg::mmio_pad_t pb_alt;
    mmio_pkg::mmio_pad_t pc_gpio;
    mmio_pkg::mmio_pad_t pc_alt;
    mmio_pkg::mmio_pad_t pd_gpio;
    mmio_pkg::mmio_pad_t pd_alt;

    function automatic logic hit(
        input mmio_pkg::mmio_wr_t     w,
        input logic [`MMIO_IDX_W-1:0] idx
    );
        return w.en && (w.idx == idx);
    endfunction

    function automatic mmio_pkg::mmio_pad_t gpio_drive(
        input logic [7:0] lvl,
        input logic [7:0] oe
    );
        mmio_pkg::mmio_pad_t p;
        p.out  = lvl;
        p.oe_n = ~oe;
        p.pull = ~oe;
        return p;
    endfunction

    function automatic mmio_pkg::mmio_pad_t merge(
        input logic [7:0]          m,
        input mmio_pkg::mmio_pad_t a,
        input mmio_pkg::mmio_pad_t g
    );
        mmio_pkg::mmio_pad_t p;
        p.out  = (m & a.out)  | (~m & g.out);
        p.oe_n = (m & a.oe_n) | (~m & g.oe_n);
        p.pull = (m & a.pull) | (~m & g.pull);
        return p;
    endfunction

    mmio_ahb_slave u_slave (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hsize_i     (hsize_i),
        .hready_i    (hready_i),
        .hwdata_i    (hwdata_i),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .hrdata_o    (hrdata_o),
        .rd_idx_o    (rd_idx),
        .rd_data_i   (rd_data),
        .wr_o        (wr)
    );

    // Register writes.
    wire we_pd   = hit(wr, `MMIO_IDX_PD);
    wire we_palt = hit(wr, `MMIO_IDX_PA_ALT);
    wire we_plvl = hit(wr, `MMIO_IDX_PA_LVL);
    wire we_pboe = hit(wr, `MMIO_IDX_PB_OE);
    wire we_pblv = hit(wr, `MMIO_IDX_PB_LVL);
    wire we_pcoe = hit(wr, `MMIO_IDX_PC_OE);
    wire we_pclv = hit(wr, `MMIO_IDX_PC_LVL);
    wire we_ctrl = hit(wr, `MMIO_IDX_CTRL);

    // The two port A registers are written independently, so a careless
    // order can let the vsync source through for a cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_a_alt_select <= `MMIO_RST_PA_ALT;
            port_a_level      <= `MMIO_RST_PA_LVL;
        end else begin
            if (we_palt) begin
                port_a_alt_select <= wr.data;
            end
            if (we_plvl) begin
                port_a_level <= wr.data;
            end
        end
    end

    // Bit 7 of port B does not exist, so it is never stored.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_b_output_enable <= `MMIO_RST_PB_OE;
            port_b_level         <= `MMIO_RST_PB_LVL;
        end else begin
            if (we_pboe) begin
                port_b_output_enable <= wr.data[6:0];
            end
            if (we_pblv) begin
                port_b_level <= wr.data[6:0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_c_output_enable <= `MMIO_RST_PC_OE;
            port_c_level         <= `MMIO_RST_PC_LVL;
        end else begin
            if (we_pcoe) begin
                port_c_output_enable <= wr.data;
            end
            if (we_pclv) begin
                port_c_level <= wr.data;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_d_control       <= `MMIO_RST_PD;
            pin_function_control <= `MMIO_RST_CTRL;
        end else begin
            if (we_pd) begin
                port_d_control <= wr.data[4:0];
            end
            if (we_ctrl) begin
                pin_function_control <= wr.data[5:0];
            end
        end
    end

    // Control fields.
    wire ext_irq_enable      = pin_function_control[`MMIO_CTL_IRQ];
    wire second_iic_enable   = pin_function_control[`MMIO_CTL_IIC2];
    wire test_pattern_enable = pin_function_control[`MMIO_CTL_PAT];
    wire divider_pins_enable = pin_function_control[`MMIO_CTL_DIV];
    wire adc0_select         = pin_function_control[`MMIO_CTL_ADC0];
    wire adc1_select         = pin_function_control[`MMIO_CTL_ADC1];
    wire portd_gpio_select   = port_d_control[`MMIO_PD_GPIO];
    wire [1:0] portd_drive_enable =
        port_d_control[`MMIO_PD_OE_MSB:`MMIO_PD_OE_LSB];
    wire [1:0] portd_level = port_d_control[`MMIO_PD_LVL_MSB:0];
    wire irq_active =
        ext_irq_enable & ~port_b_output_enable[`MMIO_PB_IRQ];

    // Read-only view of which pins are currently taken by a function.
    wire [7:0] mode_status = {
        1'b0,
        ~portd_gpio_select,
        adc1_select,
        adc0_select,
        divider_pins_enable,
        test_pattern_enable,
        second_iic_enable,
        irq_active
    };

    // Read path: data registers show the pins, write-only ones show zero.
    wire [7:0] rd_pd = {6'h00, portd_pin_i};
    wire [7:0] rd_pb = {1'b0, portb_pin_i[6:0]};
    wire [7:0] rd_ctl = {2'h0, pin_function_control};
    assign rd_data =
        (rd_idx == `MMIO_IDX_PD)     ? rd_pd :
        (rd_idx == `MMIO_IDX_PA_LVL) ? porta_pin_i :
        (rd_idx == `MMIO_IDX_PB_LVL) ? rd_pb :
        (rd_idx == `MMIO_IDX_PC_LVL) ? portc_pin_i :
        (rd_idx == `MMIO_IDX_CTRL)   ? rd_ctl :
        (rd_idx == `MMIO_IDX_MODE)   ? mode_status :
        8'h00;

    // Port A: alternates are push-pull, a level of one only floats high.
    wire [7:0] pa_alt_src = {
        hsync_out_pin_i,
        vsync_out_pin_i,
        pwm_channel_i
    };
    wire [7:0] pa_gpio_hi = ~port_a_alt_select & port_a_level;
    assign next_pa.out =
        (port_a_alt_select & pa_alt_src) |
        (~port_a_alt_select & port_a_level);
    assign next_pa.oe_n = pa_gpio_hi;
    assign next_pa.pull = pa_gpio_hi;

    // Port B.
    assign pb_gpio = gpio_drive(
        {1'b1, port_b_level},
        {1'b0, port_b_output_enable});
    wire [7:0] pb_mask = {
        1'b1,
        1'b0,
        second_iic_enable,
        second_iic_enable,
        test_pattern_enable,
        1'b0,
        divider_pins_enable,
        divider_pins_enable
    };
    assign pb_alt.out = {
        4'hC,
        pattern_out_pin_i,
        2'h3,
        divider_out_pin_i
    };
    // The second I2C pins are open-drain: they only ever pull low.
    assign pb_alt.oe_n = {
        2'h3,
        iic2_data_pin_i,
        iic2_clock_pin_i,
        1'b0,
        1'b1,
        1'b1,
        1'b0
    };
    assign pb_alt.pull = {6'h00, 1'b1, 1'b0};
    assign next_pb = merge(pb_mask, pb_alt, pb_gpio);

    // Port C: A/D inputs keep the driver setting but drop the pull-up.
    assign pc_gpio = gpio_drive(
        port_c_level,
        port_c_output_enable);
    assign pc_alt.out  = pc_gpio.out;
    assign pc_alt.oe_n = pc_gpio.oe_n;
    assign pc_alt.pull = 8'h00;
    assign next_pc = merge(
        {6'h00, adc1_select, adc0_select},
        pc_alt,
        pc_gpio);

    // Port D: open-drain DDC lines until switched to GPIO.
    assign pd_gpio = gpio_drive(
        {6'h3F, portd_level},
        {6'h00, portd_drive_enable});
    assign pd_alt.out  = 8'h00;
    assign pd_alt.oe_n = {6'h3F, ddc_data_pin_i, ddc_clock_pin_i};
    assign pd_alt.pull = 8'h00;
    assign next_pd = merge(
        {6'h3F, {2{~portd_gpio_select}}},
        pd_alt,
        pd_gpio);

    // Pads are registered so every pin sees a clean edge.
    mmio_pad_bank u_pad_a (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .next_pad_i (next_pa),
        .pad_o      (porta_pad_o)
    );

    mmio_pad_bank u_pad_b (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .next_pad_i (next_pb),
        .pad_o      (portb_pad_o)
    );

    mmio_pad_bank u_pad_c (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .next_pad_i (next_pc),
        .pad_o      (portc_pad_o)
    );

    mmio_pad_bank #(
        .RST_PULL (8'hFC)
    ) u_pad_d (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .next_pad_i (next_pd),
        .pad_o      (portd_pad_o)
    );

    // Function inputs; an idle interrupt line reads high.
    wire next_irq = irq_active ? portb_pin_i[`MMIO_PB_IRQ] : 1'b1;
    wire next_div = divider_pins_enable & portb_pin_i[`MMIO_PB_DIVI];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_irq_pin_o    <= 1'b1;
            iic2_clock_pin_o <= 1'b1;
            iic2_data_pin_o  <= 1'b1;
            divider_in_pin_o <= 1'b0;
            ddc_clock_pin_o  <= 1'b1;
            ddc_data_pin_o   <= 1'b1;
        end else begin
            ext_irq_pin_o    <= next_irq;
            iic2_clock_pin_o <= portb_pin_i[`MMIO_PB_SCL];
            iic2_data_pin_o  <= portb_pin_i[`MMIO_PB_SDA];
            divider_in_pin_o <= next_div;
            ddc_clock_pin_o  <= portd_pin_i[0];
            ddc_data_pin_o   <= portd_pin_i[1];
        end
    end
endmodule
`default_nettype wire

// >>> verif/mmio_board.sv
`default_nettype none
module mmio_board #(
    parameter logic [7:0] EXT_PU = 8'h00
) (
    // Clock.
    input  wire logic                clk_i,
    // Pad drive and board drivers.
    input  wire mmio_pkg::mmio_pad_t pad_i,
    input  wire logic [7:0]          ext_en_i,
    input  wire logic [7:0]          ext_val_i,
    // Resolved pin levels.
    output logic [7:0]               pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog = 1'h0;
    always @(posedge clk_i) begin
        tog <= ~tog;
    end
    // A board driver beats the weak pull-up, so a weak-high pin still
    // serves as an input; a floating pin toggles so no stale level passes.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ext_en_i[i]) begin
                pin_o[i] = ext_val_i[i];
            end else if (!pad_i.oe_n[i]) begin
                pin_o[i] = pad_i.out[i];
            end else if (pad_i.pull[i] || EXT_PU[i]) begin
                pin_o[i] = 1'h1;
            end else begin
                pin_o[i] = tog;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/mmio_io_ports_sva.sv
`default_nettype none
`include "mmio_defines.svh"
module mmio_io_ports_chk (
    // Clock and reset.
    input wire logic                clk_i,
    input wire logic                rst_i,
    // Bus.
    input wire logic                hsel_i,
    input wire logic [31:0]         haddr_i,
    input wire logic [1:0]          htrans_i,
    input wire logic                hwrite_i,
    input wire logic                hready_i,
    input wire logic                hreadyout_o,
    input wire logic                hresp_o,
    input wire logic [31:0]         hrdata_o,
    // Pins and pads.
    input wire logic [7:0]          porta_pin_i,
    input wire logic [7:0]          portb_pin_i,
    input wire logic [7:0]          portc_pin_i,
    input wire logic [1:0]          portd_pin_i,
    input wire mmio_pkg::mmio_pad_t porta_pad_o,
    input wire mmio_pkg::mmio_pad_t portb_pad_o,
    input wire mmio_pkg::mmio_pad_t portc_pad_o,
    input wire mmio_pkg::mmio_pad_t portd_pad_o,
    // Function sinks.
    input wire logic                ext_irq_pin_o,
    input wire logic                iic2_clock_pin_o,
    input wire logic                iic2_data_pin_o,
    input wire logic                divider_in_pin_o,
    input wire logic                ddc_clock_pin_o,
    input wire logic                ddc_data_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic       rd_req = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
    wire logic [5:0] idx    = haddr_i[7:2];
    logic [31:0]     live_rd;
    logic            known;
    // Control and status reads hold no pin level, so they are skipped.
    always_comb begin
        known   = 1'h1;
        live_rd = 32'h0;
        case (idx)
            `MMIO_IDX_PD:     live_rd = {30'h0, portd_pin_i};
            `MMIO_IDX_PA_LVL: live_rd = {24'h0, porta_pin_i};
            `MMIO_IDX_PB_LVL: live_rd = {25'h0, portb_pin_i[6:0]};
            `MMIO_IDX_PC_LVL: live_rd = {24'h0, portc_pin_i};
            `MMIO_IDX_CTRL, `MMIO_IDX_MODE: known = 1'h0;
            default: known = 1'h1;
        endcase
    end
    a_bus_okay:
        assert property (hreadyout_o && !hresp_o) else $error("bus answer");
    a_read_value:
        assert property (rd_req && known |=> hrdata_o == $past(live_rd))
        else $error("read data not pin level");
    a_rdata_hold:
        assert property (!rd_req |=> $stable(hrdata_o))
        else $error("read data moved unread");
    a_drive_pull:
        assert property (((~porta_pad_o.oe_n & porta_pad_o.pull)
            | (~portb_pad_o.oe_n & portb_pad_o.pull)
            | (~portc_pad_o.oe_n & portc_pad_o.pull)
            | (~portd_pad_o.oe_n & portd_pad_o.pull)) == 8'h00)
        else $error("pad drives with pull-up on");
    a_porta_weak:
        assert property (porta_pad_o.oe_n == porta_pad_o.pull
            && (porta_pad_o.out | ~porta_pad_o.oe_n) == 8'hFF)
        else $error("port A high is not weak");
    a_fixed_bits:
        assert property (!$past(rst_i) |-> portb_pad_o.oe_n[7]
            && !portb_pad_o.pull[7] && portd_pad_o.oe_n[7:2] == 6'h3F
            && portd_pad_o.pull[7:2] == 6'h00) else $error("unused pad on");
    a_irq_gated:
        assert property (!portb_pad_o.oe_n[6] && !$past(portb_pad_o.oe_n[6])
            |-> ext_irq_pin_o) else $error("irq seen while pin driven");
    a_iic2_follow:
        assert property (!$past(rst_i) |-> {iic2_data_pin_o,
            iic2_clock_pin_o} == $past(portb_pin_i[5:4]))
        else $error("second bus inputs do not follow pins");
    a_ddc_follow:
        assert property (!$past(rst_i) |->
            {ddc_data_pin_o, ddc_clock_pin_o} == $past(portd_pin_i))
        else $error("serial inputs off pins");
    a_div_gate:
        assert property (divider_in_pin_o |-> $past(portb_pin_i[1]))
        else $error("divider input high without pin");
    c_two_reads: cover property (rd_req ##2 rd_req);
    c_irq_low: cover property (!ext_irq_pin_o);
    c_div_high: cover property (divider_in_pin_o);
endmodule
bind mmio_io_ports mmio_io_ports_chk chk_u (.clk_i, .rst_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o,
    .hrdata_o, .porta_pin_i, .portb_pin_i, .portc_pin_i, .portd_pin_i,
    .porta_pad_o, .portb_pad_o, .portc_pad_o, .portd_pad_o, .ext_irq_pin_o,
    .iic2_clock_pin_o, .iic2_data_pin_o, .divider_in_pin_o,
    .ddc_clock_pin_o, .ddc_data_pin_o);
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'h0, rst_i = 1'h1, hsel_i = 1'h0, hwrite_i = 1'h0;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
    logic        hreadyout_o, hresp_o;
    logic [7:0]  porta_pin_i, portb_pin_i, portc_pin_i, d_pins;
    logic [1:0]  portd_pin_i;
    logic [5:0]  pwm_channel_i = 6'h2A;
    logic        hsync_out_pin_i = 1'h1, vsync_out_pin_i = 1'h0;
    logic        pattern_out_pin_i = 1'h1, divider_out_pin_i = 1'h0;
    logic        iic2_clock_pin_i = 1'h1, iic2_data_pin_i = 1'h0;
    logic        ddc_clock_pin_i = 1'h0, ddc_data_pin_i = 1'h1;
    logic        ext_irq_pin_o, iic2_clock_pin_o, iic2_data_pin_o;
    logic        divider_in_pin_o, ddc_clock_pin_o, ddc_data_pin_o;
    logic [7:0]  a_en = 8'h00, b_en = 8'h00, ext_val = 8'h00;
    int          mismatches = 0, checked = 0;
    mmio_pkg::mmio_pad_t porta_pad_o, portb_pad_o, portc_pad_o, portd_pad_o;
    assign portd_pin_i = d_pins[1:0];
    always #5 clk_i = ~clk_i;
    mmio_io_ports dut_u (.clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i, .hready_i(hreadyout_o), .hwdata_i, .hreadyout_o,
        .hresp_o, .hrdata_o, .porta_pin_i, .portb_pin_i, .portc_pin_i,
        .portd_pin_i, .porta_pad_o, .portb_pad_o, .portc_pad_o, .portd_pad_o,
        .hsync_out_pin_i, .vsync_out_pin_i, .pwm_channel_i, .pattern_out_pin_i,
        .divider_out_pin_i, .iic2_clock_pin_i, .iic2_data_pin_i,
        .ddc_clock_pin_i, .ddc_data_pin_i, .ext_irq_pin_o, .iic2_clock_pin_o,
        .iic2_data_pin_o, .divider_in_pin_o, .ddc_clock_pin_o, .ddc_data_pin_o);
    // Board pull-ups sit on the open-drain serial lines only.
    mmio_board pa_u (.clk_i, .pad_i(porta_pad_o), .ext_en_i(a_en),
        .ext_val_i(ext_val), .pin_o(porta_pin_i));
    mmio_board #(.EXT_PU(8'h30)) pb_u (.clk_i, .pad_i(portb_pad_o),
        .ext_en_i(b_en), .ext_val_i(ext_val), .pin_o(portb_pin_i));
    mmio_board pc_u (.clk_i, .pad_i(portc_pad_o), .ext_en_i(8'h00),
        .ext_val_i(ext_val), .pin_o(portc_pin_i));
    mmio_board #(.EXT_PU(8'h03)) pd_u (.clk_i, .pad_i(portd_pad_o),
        .ext_en_i(8'h00), .ext_val_i(ext_val), .pin_o(d_pins));
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [5:0] idx,
                       input logic [31:0] wd, output logic [31:0] rdata);
        int n;
        n = 0;
        hsel_i   <= 1'h1;
        haddr_i  <= {24'h0, idx, 2'h0};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        hsize_i  <= 3'h2;
        do @(posedge clk_i); while (hreadyout_o !== 1'h1 && ++n < 64);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'h1 && ++n < 64);
        rdata = hrdata_o;
        if (n >= 64) begin
            mismatches++;
            $display("mismatch at %0t: bus never ready", $time);
            conclude();
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        logic [31:0] d;
        ahb(1'h1, idx, {24'h0, v}, d);
        settle();
    endtask
    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'h0, idx, 32'h0, d);
        cmp(d, exp);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        settle();
        cmp(32'(porta_pad_o), 32'hFFFFFF);
        cmp(32'({portb_pad_o.oe_n, portb_pad_o.pull}), 32'hFF7F);
        cmp(32'(portc_pad_o), 32'hFFFFFF);
        cmp(32'({portd_pad_o.oe_n, portd_pad_o.pull}), 32'hFE00);
        cmp(32'({ddc_data_pin_o, ddc_clock_pin_o}), 32'h2);
        rd(6'h0F, 32'h2);
        wr(6'h11, 8'h5A);
        cmp(32'(porta_pad_o), 32'h5A5A5A);
        rd(6'h11, 32'h5A);
        a_en <= 8'h02;
        settle();
        rd(6'h11, 32'h58);
        a_en <= 8'h00;
        wr(6'h10, 8'hFF);
        cmp(32'(porta_pad_o), 32'hAA0000);
        rd(6'h11, 32'hAA);
        rd(6'h10, 32'h0);
        hsync_out_pin_i <= 1'h0;
        pwm_channel_i <= 6'h15;
        settle();
        cmp(32'(porta_pad_o.out), 32'h15);
        wr(6'h11, 8'h00);
        wr(6'h10, 8'h00);
        cmp(32'(porta_pad_o), 32'h0);
        wr(6'h12, 8'h8F);
        wr(6'h13, 8'h05);
        cmp(32'({portb_pad_o.oe_n, portb_pad_o.pull}), 32'hF070);
        cmp(32'(portb_pad_o.out[3:0]), 32'h5);
        rd(6'h13, 32'h75);
        rd(6'h12, 32'h0);
        wr(6'h18, 8'h0F);
        b_en <= 8'h42;
        settle();
        cmp(32'({portb_pad_o.oe_n, portb_pad_o.pull}), 32'hD242);
        cmp(32'({portb_pad_o.out[5:2], portb_pad_o.out[0]}), 32'h6);
        cmp(32'({ext_irq_pin_o, divider_in_pin_o, iic2_data_pin_o,
            iic2_clock_pin_o}), 32'h1);
        b_en <= 8'h00;
        pattern_out_pin_i <= 1'h0;
        divider_out_pin_i <= 1'h1;
        iic2_data_pin_i <= 1'h1;
        settle();
        cmp(32'({portb_pad_o.out[3], portb_pad_o.out[0], ext_irq_pin_o,
            divider_in_pin_o, iic2_data_pin_o}), 32'hF);
        wr(6'h12, 8'h4F);
        cmp(32'(ext_irq_pin_o), 32'h1);
        wr(6'h18, 8'h00);
        wr(6'h13, 8'h02);
        cmp(32'(divider_in_pin_o), 32'h0);
        wr(6'h14, 8'hF0);
        wr(6'h15, 8'h3C);
        cmp(32'({portc_pad_o.oe_n, portc_pad_o.pull}), 32'h0F0F);
        cmp(32'(portc_pad_o.out[7:4]), 32'h3);
        rd(6'h15, 32'h3F);
        rd(6'h14, 32'h0);
        wr(6'h18, 8'h30);
        cmp(32'(portc_pad_o.pull), 32'h0C);
        wr(6'h0F, 8'h1D);
        cmp(32'({portd_pad_o.out[1:0], portd_pad_o.oe_n[1:0],
            portd_pad_o.pull[1:0]}), 32'h10);
        rd(6'h0F, 32'h1);
        wr(6'h0F, 8'h11);
        cmp(32'(portd_pad_o.pull[1:0]), 32'h3);
        rd(6'h0F, 32'h3);
        rd(6'h3F, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
